// file: logic/dve_pkg.sv
// Purpose: Shared constants for the DV receive enhancement block
// Assumes: Byte addresses on a 12-bit register port, 32-bit data
// Notes: Bit 31 of a context control word selects buffer-fill mode
package dve_pkg;
    // --------------------------------------------------------------
    // Register offsets
    // --------------------------------------------------------------
    localparam logic [11:0] ENH_SET_OFS = 12'ha80;
    localparam logic [11:0] ENH_CLR_OFS = 12'ha84;
    localparam logic [11:0] CTX_CTRL_BASE = 12'h400;
    localparam logic [11:0] CTX_CTRL_STRIDE = 12'h020;
    localparam logic [11:0] CLR_ALIAS_OFS = 12'h004;
    // --------------------------------------------------------------
    // Field layouts and reset values
    // --------------------------------------------------------------
    localparam logic [31:0] ENH_RW_MASK = 32'h00003333;
    localparam logic [31:0] ENH_RESET = 32'h00000000;
    localparam int ENH_CTX_STRIDE = 4;
    localparam int STRIP_BIT = 0;
    localparam int SYNC_BIT = 1;
    localparam logic [31:0] CTRL_RW_MASK = 32'hc0008000;
    localparam logic [31:0] CTRL_RESET = 32'h00000000;
    localparam int CTRL_FILL_BIT = 31;
    localparam int CTRL_HDR_BIT = 30;
    localparam int CTRL_RUN_BIT = 15;
    localparam int CTRL_ACTIVE_BIT = 10;
    localparam logic [1:0] BRANCH_FILL_SYNC = 2'b01;
    // --------------------------------------------------------------
    // Stream constants
    // --------------------------------------------------------------
    localparam logic [7:0] TAG_FIRST_BYTE = 8'h1f;
    localparam logic [3:0] TAG_LOW_NIBBLE = 4'h7;
    localparam logic [1:0] CIP_QUADLETS = 2'h2;
    localparam logic [1:0] TAG_QUADLET = 2'h2;
    localparam logic [1:0] QIDX_MAX = 2'h3;
    typedef enum logic [0:0] {
        PH_WAIT = 1'b0,
        PH_RUN  = 1'b1
    } dve_phase_type;
endpackage

// file: logic/dve_ctx.sv
// Purpose: Per-context payload filter: header strip and frame alignment
// Assumes: Quadlets arrive on the same clock, sop marks payload quadlet 0
// Notes: Outputs are combinational; the top registers them
`timescale 1ns/1ps
module dve_ctx (
    input wire logic clk_i,            // System clock
    input wire logic rst_i,            // Synchronous reset, high
    input wire logic valid_i,          // Quadlet for this context
    input wire logic sop_i,            // First payload quadlet
    input wire logic [31:0] data_i,    // Quadlet data
    input wire logic strip_en_i,       // Effective header strip
    input wire logic sync_en_i,        // Effective frame sync
    input wire logic at_frame_i,       // Buffer sits at a frame start
    output logic keep_o,               // Store this quadlet
    output logic resync_o              // Jump to resync descriptor
);
    typedef struct packed {
        logic [1:0] qidx;
        dve_pkg::dve_phase_type phase;
    } dve_ctx_state_type;

    dve_ctx_state_type s_q, s_d;
    logic [1:0] idx;
    logic tag_hit;

    // Quadlet index of the current beat and tag match on it
    assign idx = sop_i ? 2'h0 : s_q.qidx;
    assign tag_hit = (idx == dve_pkg::TAG_QUADLET) &&
                     (data_i[31:24] == dve_pkg::TAG_FIRST_BYTE) &&
                     (data_i[19:16] == dve_pkg::TAG_LOW_NIBBLE); // R10

    // Next state and decisions
    always_comb begin
        s_d = s_q;
        keep_o = 1'b0;
        resync_o = 1'b0;
        if (!sync_en_i) begin
            s_d.phase = dve_pkg::PH_WAIT;
        end
        if (valid_i) begin
            s_d.qidx = (idx == dve_pkg::QIDX_MAX) ? idx : idx + 2'h1;
            // Strip only the CIP quadlets, later ones pass unless frame sync still waits
            keep_o = !(strip_en_i && idx < dve_pkg::CIP_QUADLETS); // R4
            if (sync_en_i) begin // R6
                unique case (s_q.phase)
                    dve_pkg::PH_WAIT: begin
                        // Nothing goes to memory until a frame start
                        if (tag_hit) begin // R11
                            s_d.phase = dve_pkg::PH_RUN;
                        end else begin
                            keep_o = 1'b0; // R11
                        end
                    end
                    dve_pkg::PH_RUN: begin
                        // A frame start mid-buffer breaks alignment
                        if (tag_hit && !at_frame_i) begin
                            resync_o = 1'b1; // R7
                        end
                    end
                endcase
            end
        end
    end

    // State register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_q <= '{qidx: 2'h0, phase: dve_pkg::PH_WAIT};
        end else begin
            s_q <= s_d;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence hdr_beat_s;
        valid_i && strip_en_i && idx < dve_pkg::CIP_QUADLETS;
    endsequence

    strip_header_a: assert property (hdr_beat_s |-> !keep_o) // R4
        else $error("CIP quadlet stored while stripping");
    wait_no_store_a: assert property ( // R11
        (sync_en_i && s_q.phase == dve_pkg::PH_WAIT && !tag_hit) |-> !keep_o)
        else $error("Quadlet stored before frame start");
    resync_when_run_a: assert property ( // R7
        resync_o |-> (s_q.phase == dve_pkg::PH_RUN && sync_en_i && tag_hit))
        else $error("Resync outside running frame sync");
    tag_enters_run_a: assert property ( // R6
        (valid_i && sync_en_i && tag_hit) ##1 sync_en_i |-> s_q.phase == dve_pkg::PH_RUN)
        else $error("Frame start did not align context");
endmodule

// file: logic/dve_top.sv
// Purpose: DV receive enhancement control for four receive contexts
// Assumes: Register port and packet stream share SYS_CLK_I (40 MHz)
// Notes: Set/clear aliases for enhancements and context control words
//
// How it works
// R1 - Software edits bits only while context stopped (not enforced: writes take effect at once, even mid-packet)
// R2 - Set alias ORs ones, clear alias removes
// R3 - Upper and reserved bit pairs read zero
// R4 - Strip bit drops first two payload quadlets
// R5 - Strip ignored when packet header kept
// R6 - Frame sync needs buffer-fill and branch 01b
// R7 - Misplaced frame start jumps to resync descriptor
// R8 - Frame sync needs strip on, header off
// R9 - Context control pairs at 400h to 464h
// R10 - Frame start is 1Fh then low nibble 7h
// R11 - Store nothing before first frame start packet
// R12 - Bits reset zero, zero writes change nothing
`timescale 1ns/1ps
module dve_top #(
    parameter int NUM_CTX = 4              // Receive contexts
) (
    input wire logic SYS_CLK_I,            // System clock
    input wire logic SYS_RST_I,            // Synchronous reset, high
    input wire logic [11:0] REG_ADDR_I,    // Register byte address
    input wire logic REG_WR_I,             // Write strobe
    input wire logic REG_RD_I,             // Read strobe
    input wire logic [31:0] REG_WDATA_I,   // Write data
    output logic [31:0] REG_RDATA_O,       // Read data
    output logic REG_ACK_O,                // Access done pulse
    input wire logic PKT_VALID_I,          // Payload quadlet valid
    input wire logic PKT_SOP_I,            // First payload quadlet
    input wire logic [1:0] PKT_CTX_I,      // Receiving context
    input wire logic [31:0] PKT_DATA_I,    // Payload quadlet
    input wire logic [7:0] BRANCH_CTL_I,   // Descriptor branch ctl per ctx
    input wire logic [3:0] AT_FRAME_I,     // Buffer at frame start per ctx
    output logic STORE_VALID_O,            // Quadlet to memory
    output logic [1:0] STORE_CTX_O,        // Its context
    output logic [31:0] STORE_DATA_O,      // Its data
    output logic [3:0] RESYNC_JUMP_O,      // Load resync pointer pulse
    output logic [3:0] CTX_RUN_O           // Context run bits
);
    // The decode below is written for four contexts; refuse any other count
    if (NUM_CTX != 4) begin : g_bad_ctx
        $error("dve_top serves exactly four contexts");
    end

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [31:0] enh;
        logic [3:0][31:0] ctrl;
        logic [31:0] rdata;
        logic ack;
        logic st_valid;
        logic [1:0] st_ctx;
        logic [31:0] st_data;
        logic [3:0] resync;
    } dve_top_state_type;

    dve_top_state_type s_q, s_d;
    logic [3:0] strip_eff, sync_eff, keep, resync;

    // Byte address of a context control word, set or clear alias
    function automatic logic [11:0] ctrl_addr(input int n, input logic clr);
        logic [11:0] a;
        a = dve_pkg::CTX_CTRL_BASE + dve_pkg::CTX_CTRL_STRIDE * 12'(n); // R9
        ctrl_addr = clr ? a + dve_pkg::CLR_ALIAS_OFS : a;
    endfunction

    // Context control word as read, active mirrors run
    function automatic logic [31:0] ctrl_view(input logic [31:0] c);
        logic [31:0] v;
        v = c;
        v[dve_pkg::CTRL_ACTIVE_BIT] = c[dve_pkg::CTRL_RUN_BIT];
        ctrl_view = v;
    endfunction

    // ------------------------------------------------------------------
    // Per-context qualification and filters
    // ------------------------------------------------------------------
    for (genvar n = 0; n < 4; n++) begin : g_ctx
        logic hdr_kept, strip_bit, sync_bit, fill;
        assign hdr_kept = s_q.ctrl[n][dve_pkg::CTRL_HDR_BIT];
        assign fill = s_q.ctrl[n][dve_pkg::CTRL_FILL_BIT];
        assign strip_bit = s_q.enh[n*dve_pkg::ENH_CTX_STRIDE + dve_pkg::STRIP_BIT];
        assign sync_bit = s_q.enh[n*dve_pkg::ENH_CTX_STRIDE + dve_pkg::SYNC_BIT];
        // A kept isochronous header disables both enhancements
        assign strip_eff[n] = strip_bit && !hdr_kept; // R5
        assign sync_eff[n] = sync_bit && strip_eff[n] && fill &&
                             (BRANCH_CTL_I[2*n +: 2] == dve_pkg::BRANCH_FILL_SYNC); // R8 R6

        dve_ctx u_ctx (
            .clk_i(SYS_CLK_I),
            .rst_i(SYS_RST_I),
            .valid_i(PKT_VALID_I && PKT_CTX_I == 2'(n)),
            .sop_i(PKT_SOP_I),
            .data_i(PKT_DATA_I),
            .strip_en_i(strip_eff[n]),
            .sync_en_i(sync_eff[n]),
            .at_frame_i(AT_FRAME_I[n]),
            .keep_o(keep[n]),
            .resync_o(resync[n])
        );
    end

    // ------------------------------------------------------------------
    // Register port and output path
    // ------------------------------------------------------------------
    // Software is trusted to touch a context only while it is stopped;
    // the bits change at once, mid-packet, if it does not.
    always_comb begin
        s_d = s_q;
        s_d.ack = REG_WR_I || REG_RD_I;
        s_d.rdata = 32'h00000000;
        if (REG_WR_I) begin
            // Only ones act, so a zero leaves its bit alone
            if (REG_ADDR_I == dve_pkg::ENH_SET_OFS) begin
                s_d.enh = s_q.enh | (REG_WDATA_I & dve_pkg::ENH_RW_MASK); // R2 R12
            end
            if (REG_ADDR_I == dve_pkg::ENH_CLR_OFS) begin
                s_d.enh = s_q.enh & ~(REG_WDATA_I & dve_pkg::ENH_RW_MASK); // R2 R12
            end
            for (int n = 0; n < 4; n++) begin
                if (REG_ADDR_I == ctrl_addr(n, 1'b0)) begin
                    s_d.ctrl[n] = s_q.ctrl[n] | (REG_WDATA_I & dve_pkg::CTRL_RW_MASK); // R9
                end
                if (REG_ADDR_I == ctrl_addr(n, 1'b1)) begin
                    s_d.ctrl[n] = s_q.ctrl[n] & ~(REG_WDATA_I & dve_pkg::CTRL_RW_MASK);
                end
            end
        end
        if (REG_RD_I) begin
            // Reserved bits never stored, so they read as zero
            if (REG_ADDR_I == dve_pkg::ENH_SET_OFS || REG_ADDR_I == dve_pkg::ENH_CLR_OFS) begin
                s_d.rdata = s_q.enh & dve_pkg::ENH_RW_MASK; // R3 R2
            end
            for (int n = 0; n < 4; n++) begin
                if (REG_ADDR_I == ctrl_addr(n, 1'b0) || REG_ADDR_I == ctrl_addr(n, 1'b1)) begin
                    s_d.rdata = ctrl_view(s_q.ctrl[n]);
                end
            end
        end
        // Filtered quadlets leave one cycle after they arrive
        s_d.st_valid = PKT_VALID_I && keep[PKT_CTX_I];
        s_d.st_ctx = PKT_CTX_I;
        s_d.st_data = PKT_DATA_I;
        s_d.resync = resync; // R7
    end

    // State register
    always_ff @(posedge SYS_CLK_I) begin
        if (SYS_RST_I) begin
            s_q.enh <= dve_pkg::ENH_RESET; // R12
            s_q.ctrl <= {4{dve_pkg::CTRL_RESET}};
            s_q.rdata <= 32'h00000000;
            s_q.ack <= 1'b0;
            s_q.st_valid <= 1'b0;
            s_q.st_ctx <= 2'h0;
            s_q.st_data <= 32'h00000000;
            s_q.resync <= 4'h0;
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs straight from flops
    assign REG_RDATA_O = s_q.rdata;
    assign REG_ACK_O = s_q.ack;
    assign STORE_VALID_O = s_q.st_valid;
    assign STORE_CTX_O = s_q.st_ctx;
    assign STORE_DATA_O = s_q.st_data;
    assign RESYNC_JUMP_O = s_q.resync;
    for (genvar n = 0; n < 4; n++) begin : g_run
        assign CTX_RUN_O[n] = s_q.ctrl[n][dve_pkg::CTRL_RUN_BIT];
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge SYS_CLK_I); endclocking
    default disable iff (SYS_RST_I);

    sequence set_wr_s;
        REG_WR_I && REG_ADDR_I == dve_pkg::ENH_SET_OFS;
    endsequence
    sequence clr_wr_s;
        REG_WR_I && REG_ADDR_I == dve_pkg::ENH_CLR_OFS;
    endsequence

    // Write data of the strobe cycle is recovered with $past after the edge
    enh_set_alias_a: assert property ( // R2
        set_wr_s |=> (s_q.enh & $past(REG_WDATA_I) & dve_pkg::ENH_RW_MASK) ==
                     ($past(REG_WDATA_I) & dve_pkg::ENH_RW_MASK))
        else $error("Set alias did not set bits");
    enh_clr_alias_a: assert property ( // R2
        clr_wr_s |=> (s_q.enh & $past(REG_WDATA_I)) == 32'h00000000)
        else $error("Clear alias did not clear bits");
    enh_reserved_zero_a: assert property ((s_q.enh & ~dve_pkg::ENH_RW_MASK) == 32'h0) // R3
        else $error("Reserved enhancement bit set");
    zero_keeps_bits_a: assert property ( // R12
        (set_wr_s or clr_wr_s) |=> ((s_q.enh ^ $past(s_q.enh)) & ~$past(REG_WDATA_I)) == 32'h0)
        else $error("Zero write changed a bit");
    read_zero_a: assert property ( // R3
        (REG_RD_I && (REG_ADDR_I == dve_pkg::ENH_SET_OFS ||
                      REG_ADDR_I == dve_pkg::ENH_CLR_OFS))
            |=> (REG_RDATA_O & ~dve_pkg::ENH_RW_MASK) == 32'h0)
        else $error("Reserved enhancement bit read as one");
    read_back_a: assert property ( // R2
        (REG_RD_I && REG_ADDR_I == dve_pkg::ENH_CLR_OFS && !REG_WR_I)
            |=> REG_ACK_O && REG_RDATA_O == $past(s_q.enh))
        else $error("Clear alias read back wrong value");
    hdr_kept_a: assert property ( // R5
        (PKT_VALID_I && PKT_SOP_I && s_q.ctrl[PKT_CTX_I][dve_pkg::CTRL_HDR_BIT])
            |=> STORE_VALID_O)
        else $error("Quadlet stripped while header kept");
    // Without an effective strip, frame sync must never hold a quadlet back
    sync_qual_a: assert property ( // R8
        (PKT_VALID_I && !strip_eff[PKT_CTX_I]) |=> STORE_VALID_O)
        else $error("Frame sync without header strip");
    resync_pulse_a: assert property (RESYNC_JUMP_O != 4'h0 |-> $past(PKT_VALID_I)) // R7
        else $error("Resync jump without a quadlet");
endmodule

// file: sim/dve_stream_model.sv
// Purpose: Isochronous payload source and host memory sink for the DV block
// Assumes: Four payload quadlets per packet, quadlet 2 chosen by the caller
// Notes: Idle data lines toggle each cycle so a stale quadlet never looks fresh
`timescale 1ns/1ps
module dve_stream_model (
    input wire logic clk_i,               // System clock
    output logic valid_o,                 // Payload quadlet valid
    output logic sop_o,                   // First payload quadlet
    output logic [1:0] ctx_o,             // Receiving context
    output logic [31:0] data_o,           // Payload quadlet
    input wire logic store_valid_i,       // Quadlet written to memory
    input wire logic [1:0] store_ctx_i,   // Its context
    input wire logic [31:0] store_data_i  // Its data
);
    logic busy;
    logic [33:0] mem_q[$];
    // ----------------------------------------------------------
    // Packet source and memory capture
    // ----------------------------------------------------------
    initial begin
        busy = 1'b0;
        valid_o = 1'b0;
        sop_o = 1'b0;
        ctx_o = 2'h0;
        data_o = 32'h0;
    end
    // Outside packets the bus carries noise, the last quadlet and its inverse in turn
    always @(posedge clk_i) begin
        if (!busy) data_o <= ~data_o;
    end
    // Memory keeps context and data of every stored quadlet
    always @(posedge clk_i) begin
        if (store_valid_i) mem_q.push_back({store_ctx_i, store_data_i});
    end
    // One payload; gap idle cycles after each quadlet model a slow sender
    task automatic send(input logic [1:0] c, input logic [31:0] q2, input int gap);
        busy = 1'b1;
        for (int k = 0; k < 4; k++) begin
            @(posedge clk_i);
            valid_o <= 1'b1;
            sop_o <= (k == 0);
            ctx_o <= c;
            data_o <= (k == 2) ? q2 : {4'ha, c, 2'(k), 24'h5a5a3c};
            repeat (gap) begin
                @(posedge clk_i);
                valid_o <= 1'b0;
                sop_o <= 1'b0;
                data_o <= ~data_o;
            end
        end
        @(posedge clk_i);
        valid_o <= 1'b0;
        sop_o <= 1'b0;
        busy = 1'b0;
    endtask
endmodule

// file: sim/tb_iso_rx_dv_enhance.sv
// Purpose: Self-checking bench for the DV receive enhancement block
// Assumes: One-cycle register strobes, ack one cycle after each strobe
// Notes: Quadlet 2 with 1f in byte 0 and low nibble 7 in byte 1 is a frame start
`timescale 1ns/1ps
module tb_iso_rx_dv_enhance;
    logic SYS_CLK_I, SYS_RST_I, REG_WR_I, REG_RD_I, REG_ACK_O, PKT_VALID_I, PKT_SOP_I;
    logic STORE_VALID_O;
    logic [11:0] REG_ADDR_I;
    logic [31:0] REG_WDATA_I, REG_RDATA_O, PKT_DATA_I, STORE_DATA_O;
    logic [1:0] PKT_CTX_I, STORE_CTX_O;
    logic [7:0] BRANCH_CTL_I;
    logic [3:0] AT_FRAME_I, RESYNC_JUMP_O, CTX_RUN_O;
    int error_cnt, check_count, cyc, rs_cnt, rs0;
    localparam logic [31:0] TAG = 32'h1fa70000;
    localparam logic [31:0] NOTAG = 32'h1fa60000;

    dve_top #(.NUM_CTX(4)) uut (.SYS_CLK_I(SYS_CLK_I), .SYS_RST_I(SYS_RST_I),
        .REG_ADDR_I(REG_ADDR_I), .REG_WR_I(REG_WR_I), .REG_RD_I(REG_RD_I),
        .REG_WDATA_I(REG_WDATA_I), .REG_RDATA_O(REG_RDATA_O), .REG_ACK_O(REG_ACK_O),
        .PKT_VALID_I(PKT_VALID_I), .PKT_SOP_I(PKT_SOP_I), .PKT_CTX_I(PKT_CTX_I),
        .PKT_DATA_I(PKT_DATA_I), .BRANCH_CTL_I(BRANCH_CTL_I), .AT_FRAME_I(AT_FRAME_I),
        .STORE_VALID_O(STORE_VALID_O), .STORE_CTX_O(STORE_CTX_O),
        .STORE_DATA_O(STORE_DATA_O), .RESYNC_JUMP_O(RESYNC_JUMP_O), .CTX_RUN_O(CTX_RUN_O));
    dve_stream_model src (.clk_i(SYS_CLK_I), .valid_o(PKT_VALID_I), .sop_o(PKT_SOP_I),
        .ctx_o(PKT_CTX_I), .data_o(PKT_DATA_I), .store_valid_i(STORE_VALID_O),
        .store_ctx_i(STORE_CTX_O), .store_data_i(STORE_DATA_O));

    // ----------------------------------------------------------
    // Clock, watchdog and jump counter
    // ----------------------------------------------------------
    initial begin
        SYS_CLK_I = 1'b0;
        forever #12.5 SYS_CLK_I = ~SYS_CLK_I;
    end
    // Whole run needs about 270 cycles; 5000 leaves room for slow packets
    always @(posedge SYS_CLK_I) begin
        cyc++;
        if (RESYNC_JUMP_O[3]) rs_cnt++;
        if (cyc == 5000) begin
            error_cnt++;
            results();
        end
    end

    task automatic results();
        if (error_cnt == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [33:0] got, input logic [33:0] exp);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Register access: strobe one cycle, ack and data stand the cycle after
    task automatic acc(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge SYS_CLK_I);
        REG_ADDR_I <= a;
        REG_WDATA_I <= d;
        REG_WR_I <= wr;
        REG_RD_I <= !wr;
        @(posedge SYS_CLK_I);
        REG_WR_I <= 1'b0;
        REG_RD_I <= 1'b0;
        // Ack and data stand only until the next edge, so look just after this one
        #1 chk({33'h0, REG_ACK_O}, 34'h1);
        if (!wr) chk({2'h0, REG_RDATA_O}, {2'h0, d});
        @(posedge SYS_CLK_I);
    endtask
    function automatic logic [31:0] qw(input logic [1:0] c, input int k, input logic [31:0] q2);
        return (k == 2) ? q2 : {4'ha, c, 2'(k), 24'h5a5a3c};
    endfunction
    // Send one packet and expect quadlets first..3 in memory, in order
    task automatic pkt(input logic [1:0] c, input int gap, input logic [31:0] q2, input int first);
        src.mem_q.delete();
        src.send(c, q2, gap);
        repeat (2) @(posedge SYS_CLK_I);
        chk(34'(src.mem_q.size()), 34'(4 - first));
        for (int k = first; k < 4; k++) begin
            if (src.mem_q.size() > 0) chk(src.mem_q.pop_front(), {c, qw(c, k, q2)});
        end
    endtask

    // ----------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------
    initial begin
        SYS_RST_I = 1'b1;
        REG_ADDR_I = 12'h0;
        REG_WDATA_I = 32'h0;
        REG_WR_I = 1'b0;
        REG_RD_I = 1'b0;
        BRANCH_CTL_I = 8'h0;
        AT_FRAME_I = 4'h0;
        repeat (6) @(posedge SYS_CLK_I);
        SYS_RST_I <= 1'b0;
        acc(1'b0, 12'ha80, 32'h0);
        acc(1'b1, 12'ha80, 32'hffffffff);
        acc(1'b0, 12'ha80, 32'h00003333);
        acc(1'b0, 12'ha84, 32'h00003333);
        acc(1'b1, 12'ha84, 32'h0);
        acc(1'b0, 12'ha80, 32'h00003333);
        acc(1'b1, 12'ha84, 32'h00000011);
        acc(1'b0, 12'ha84, 32'h00003322);
        acc(1'b1, 12'ha84, 32'hffffffff);
        acc(1'b0, 12'ha80, 32'h0);
        acc(1'b0, 12'ha90, 32'h0);
        // Each context word: run set, active follows run, clear alias removes it
        for (int n = 0; n < 4; n++) begin
            acc(1'b0, 12'h400 + 12'(32 * n), 32'h0);
            acc(1'b1, 12'h400 + 12'(32 * n), 32'h00008000);
            acc(1'b0, 12'h404 + 12'(32 * n), 32'h00008400);
            chk({30'h0, CTX_RUN_O}, 34'(4'h1 << n));
            acc(1'b1, 12'h404 + 12'(32 * n), 32'h00008000);
            acc(1'b0, 12'h400 + 12'(32 * n), 32'h0);
        end
        pkt(2'd0, 0, NOTAG, 0);
        // Strip on every context, fast and slow senders
        for (int n = 0; n < 4; n++) begin
            acc(1'b1, 12'ha80, 32'h1 << (4 * n));
            pkt(2'(n), n % 2, NOTAG, 2);
            acc(1'b1, 12'ha84, 32'h1 << (4 * n));
        end
        acc(1'b1, 12'h440, 32'h40000000);
        acc(1'b1, 12'ha80, 32'h00000100);
        pkt(2'd2, 0, NOTAG, 0);
        acc(1'b1, 12'h444, 32'h40000000);
        acc(1'b1, 12'ha84, 32'h00000100);
        // Frame sync needs branch 01 and the strip bit
        acc(1'b1, 12'h400, 32'h80000000);
        acc(1'b1, 12'ha80, 32'h00000003);
        pkt(2'd0, 0, NOTAG, 2);
        acc(1'b1, 12'ha84, 32'h00000001);
        BRANCH_CTL_I <= 8'h01;
        pkt(2'd0, 0, NOTAG, 0);
        acc(1'b1, 12'ha84, 32'h00000002);
        acc(1'b1, 12'h404, 32'h80000000);
        // Context 3 waits for a frame start, then jumps on a misplaced one
        BRANCH_CTL_I <= 8'h40;
        AT_FRAME_I <= 4'h8;
        acc(1'b1, 12'h460, 32'h80000000);
        acc(1'b1, 12'ha80, 32'h00003000);
        pkt(2'd3, 1, NOTAG, 4);
        pkt(2'd3, 0, TAG, 2);
        pkt(2'd3, 2, NOTAG, 2);
        pkt(2'd3, 0, TAG, 2);
        chk(34'(rs_cnt), 34'h0);
        AT_FRAME_I <= 4'h0;
        rs0 = rs_cnt;
        pkt(2'd3, 0, TAG, 2);
        chk(34'(rs_cnt - rs0), 34'h1);
        results();
    end
endmodule
